// ### common/uwr_consts.vh
// Overview of operation
// - leaving deep sleep takes about 25 us and any receive traffic in that time is dropped.
// - the receiver neither samples nor delivers characters while in deep sleep.
// - once awake, the first falling edge seen on the line is taken as a start bit.
// - a falling edge on the receive line during deep sleep requests the wake.
// - while sleep_inhibit_n is low the block never enters any sleep state.
// - in command mode every 0x00 byte is discarded and never starts a packet.
// - in data-pipe mode a 0x00 received while awake is forwarded as payload.
// - deep sleep can be avoided by lowering the system sleep level, or the pipe sleep level while pipe_open is high.
// - the effective sleep level is the minimum of system, open-pipe and pulse-width limits.
// - cpu_asleep_indicator is low while awake and high while asleep.
// - forced_shutdown_n low forces hibernation regardless of everything else.
`ifndef UWR_CONSTS_VH
`define UWR_CONSTS_VH
`define UWR_CLK_MHZ 25
`define UWR_WAKE_NS 25000
`define UWR_WAKE_CYC ((`UWR_WAKE_NS * `UWR_CLK_MHZ) / 1000)
`define UWR_LVL_NONE 2'h0
`define UWR_LVL_NORMAL 2'h1
`define UWR_LVL_DEEP 2'h2
`define UWR_SYS_LVL_RST 2'h1
`define UWR_PIPE_LVL_RST 2'h2
`define UWR_NULL_BYTE 8'h00
`define UWR_BAUD_DIV_RST 16'h00D9
`define UWR_ADDR_CTRL 4'h0
`define UWR_ADDR_DIV 4'h4
`define UWR_ADDR_STAT 4'h8
`define UWR_ADDR_DATA 4'hC
`define UWR_RESP_OK 2'h0
`define UWR_RESP_ERR 2'h2
`endif

// ### logic/uwr_rx_core.v
`timescale 1ns/1ns
`default_nettype none
`include "uwr_consts.vh"
// -----------------------------------------------------------------------------
// 8/N/1 receiver, enabled only when the cpu is awake
// -----------------------------------------------------------------------------
module uwr_rx_core (
  input wire aclk,
  input wire aresetn,
  input wire enable,
  input wire rxd,
  input wire [15:0] baud_div,
  output reg byte_valid,
  output reg [7:0] byte_data
);
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_STOP = 2'h3;
  reg [1:0] state_reg;
  reg [15:0] cnt_reg;
  reg [2:0] bit_reg;
  reg rxd_d_reg;
  // frame engine; disabled logic holds idle so traffic is dropped
  always @(posedge aclk) begin
    if (!aresetn || !enable) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      rxd_d_reg <= 1'b1;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      rxd_d_reg <= rxd;
      byte_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (rxd_d_reg && !rxd) begin
            state_reg <= ST_START;
            cnt_reg <= {1'b0, baud_div[15:1]};
          end
        end
        ST_START: begin
          if (cnt_reg == 16'h0000) begin
            cnt_reg <= baud_div - 16'h0001; // count runs n-1 down to 0, n clocks per bit
            bit_reg <= 3'h0;
            state_reg <= rxd ? ST_IDLE : ST_DATA;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        ST_DATA: begin
          if (cnt_reg == 16'h0000) begin
            cnt_reg <= baud_div - 16'h0001;
            byte_data <= {rxd, byte_data[7:1]};
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              state_reg <= ST_STOP;
            end
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        ST_STOP: begin
          if (cnt_reg == 16'h0000) begin
            byte_valid <= rxd;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // uwr_rx_core
`default_nettype wire

// ### logic/uwr_wake_rx.v
`timescale 1ns/1ns
`default_nettype none
`include "uwr_consts.vh"
// -----------------------------------------------------------------------------
// sleep control and wake-on-receive front end with axi4-lite registers
// -----------------------------------------------------------------------------
module uwr_wake_rx #(
  parameter WAKE_CYC = `UWR_WAKE_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire uart_rxd,
  input wire sleep_inhibit_n,
  input wire forced_shutdown_n,
  input wire pipe_open,
  output reg cpu_asleep_indicator,
  output reg hibernating,
  output reg [7:0] pipe_data,
  output reg pipe_valid
);
  localparam ST_ACTIVE = 2'h0;
  localparam ST_NORMAL = 2'h1;
  localparam ST_DEEP = 2'h2;
  localparam ST_WAKING = 2'h3;
  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  reg [1:0] sys_lvl_reg;
  reg [1:0] pipe_lvl_reg;
  reg pwm_on_reg;
  reg pipe_mode_reg;
  reg sleep_req_reg;
  reg [15:0] baud_div_reg;
  reg [7:0] cmd_data_reg;
  reg cmd_full_reg;
  reg [31:0] drop_cnt_reg;
  reg [1:0] state_reg;
  reg [15:0] wake_cnt_reg;
  reg rxd_d_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg rd_data_sel_reg;
  wire rx_valid;
  wire [7:0] rx_data;
  wire awake;
  wire [1:0] eff_lvl;
  function [1:0] lvl_min;
    input [1:0] a;
    input [1:0] b;
    begin
      lvl_min = (a < b) ? a : b;
    end
  endfunction
  // effective sleep depth from all limiting sources
  assign eff_lvl = lvl_min(lvl_min(sys_lvl_reg, pipe_open ? pipe_lvl_reg : `UWR_LVL_DEEP),
    pwm_on_reg ? `UWR_LVL_NORMAL : `UWR_LVL_DEEP);
  assign awake = (state_reg == ST_ACTIVE) || (state_reg == ST_NORMAL);
  // ---------------------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_ACTIVE;
      wake_cnt_reg <= 16'h0000;
      rxd_d_reg <= 1'b1;
      cpu_asleep_indicator <= 1'b0;
      hibernating <= 1'b0;
    end else begin
      rxd_d_reg <= uart_rxd;
      hibernating <= !forced_shutdown_n;
      cpu_asleep_indicator <= !forced_shutdown_n || state_reg == ST_DEEP
        || state_reg == ST_WAKING;
      if (!forced_shutdown_n) begin
        state_reg <= ST_ACTIVE;
      end else begin
        case (state_reg)
          ST_ACTIVE, ST_NORMAL: begin
            if (!sleep_inhibit_n || !sleep_req_reg || eff_lvl == `UWR_LVL_NONE) begin
              state_reg <= ST_ACTIVE;
            end else if (eff_lvl == `UWR_LVL_DEEP) begin
              state_reg <= ST_DEEP;
            end else begin
              state_reg <= ST_NORMAL;
            end
          end
          ST_DEEP: begin
            if ((rxd_d_reg && !uart_rxd) || !sleep_inhibit_n) begin
              state_reg <= ST_WAKING;
              wake_cnt_reg <= WAKE_CYC[15:0];
            end
          end
          ST_WAKING: begin
            if (wake_cnt_reg <= 16'h0001) begin
              state_reg <= ST_ACTIVE;
            end else begin
              wake_cnt_reg <= wake_cnt_reg - 16'h0001;
            end
          end
          default: begin
            state_reg <= ST_ACTIVE;
          end
        endcase
      end
    end
  end
  // receiver runs only while awake and not hibernating
  uwr_rx_core u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(awake && forced_shutdown_n),
    .rxd(uart_rxd),
    .baud_div(baud_div_reg),
    .byte_valid(rx_valid),
    .byte_data(rx_data)
  );
  // ---------------------------------------------------------------------------
  // axi4-lite slave and byte routing
  // ---------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UWR_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `UWR_RESP_OK;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h00000000;
      rd_data_sel_reg <= 1'b0;
      sys_lvl_reg <= `UWR_SYS_LVL_RST;
      pipe_lvl_reg <= `UWR_PIPE_LVL_RST;
      pwm_on_reg <= 1'b0;
      pipe_mode_reg <= 1'b0;
      sleep_req_reg <= 1'b0;
      baud_div_reg <= `UWR_BAUD_DIV_RST;
      cmd_data_reg <= 8'h00;
      cmd_full_reg <= 1'b0;
      drop_cnt_reg <= 32'h00000000;
      pipe_data <= 8'h00;
      pipe_valid <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      pipe_valid <= 1'b0;
      // received byte routing; set beats a same-cycle read clear
      if (s_axi_rvalid && s_axi_rready && rd_data_sel_reg && !rx_valid) begin
        cmd_full_reg <= 1'b0;
      end
      if (rx_valid) begin
        if (pipe_mode_reg) begin
          pipe_data <= rx_data;
          pipe_valid <= 1'b1;
        end else if (rx_data == `UWR_NULL_BYTE) begin
          drop_cnt_reg <= drop_cnt_reg + 32'h00000001;
        end else begin
          cmd_data_reg <= rx_data;
          cmd_full_reg <= 1'b1;
        end
      end
      if (s_axi_awvalid && !aw_got_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
      if (aw_got_reg && w_got_reg) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `UWR_RESP_OK;
        case (aw_addr_reg)
          `UWR_ADDR_CTRL: begin
            sys_lvl_reg <= w_data_reg[1:0];
            pipe_lvl_reg <= w_data_reg[3:2];
            pwm_on_reg <= w_data_reg[4];
            pipe_mode_reg <= w_data_reg[5];
            sleep_req_reg <= w_data_reg[6];
          end
          `UWR_ADDR_DIV: begin
            baud_div_reg <= w_data_reg[15:0];
          end
          `UWR_ADDR_STAT, `UWR_ADDR_DATA: begin
          end
          default: begin
            s_axi_bresp <= `UWR_RESP_ERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `UWR_RESP_OK;
        rd_data_sel_reg <= (s_axi_araddr == `UWR_ADDR_DATA); // only a data read clears full
        case (s_axi_araddr)
          `UWR_ADDR_CTRL: s_axi_rdata <= {25'h0000000, sleep_req_reg, pipe_mode_reg,
            pwm_on_reg, pipe_lvl_reg, sys_lvl_reg};
          `UWR_ADDR_DIV: s_axi_rdata <= {16'h0000, baud_div_reg};
          `UWR_ADDR_STAT: s_axi_rdata <= {26'h0000000, !forced_shutdown_n, eff_lvl,
            state_reg, awake};
          `UWR_ADDR_DATA: s_axi_rdata <= {23'h000000, cmd_full_reg, cmd_data_reg};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `UWR_RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // uwr_wake_rx
`default_nettype wire

// ### verif/uwr_wake_rx_properties.sv
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------------------
// sleep and wake checker on the top ports
// -----------------------------------------------------------------------------
module uwr_wake_rx_properties #(
  parameter WAKE_CYC = 625
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic uart_rxd,
  input wire logic sleep_inhibit_n,
  input wire logic forced_shutdown_n,
  input wire logic cpu_asleep_indicator,
  input wire logic hibernating,
  input wire logic pipe_valid
);
  localparam int WMAX = 1000;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // shutdown pin wins over all else
  a_hib_enter: assert property (!forced_shutdown_n |=> hibernating && cpu_asleep_indicator)
    else $error("shutdown not followed");
  a_hib_leave: assert property (forced_shutdown_n |=> !hibernating)
    else $error("hibernate held too long");
  // inhibit keeps an awake cpu awake
  a_inhibit_awake: assert property (!sleep_inhibit_n && forced_shutdown_n
    ##1 !cpu_asleep_indicator && forced_shutdown_n |=> !cpu_asleep_indicator)
    else $error("slept with inhibit low");
  a_inhibit_wakes: assert property (!sleep_inhibit_n && forced_shutdown_n |-> ##[0:WMAX]
    (!cpu_asleep_indicator || sleep_inhibit_n || !forced_shutdown_n))
    else $error("inhibit did not wake");
  // a start edge in deep sleep wakes, but not at once
  a_wake_hold: assert property ($fell(uart_rxd) && cpu_asleep_indicator && !hibernating
    && forced_shutdown_n |=> cpu_asleep_indicator [*8])
    else $error("wake too fast");
  a_wake_done: assert property ($fell(uart_rxd) && cpu_asleep_indicator && !hibernating
    && forced_shutdown_n |-> ##[1:WMAX] !cpu_asleep_indicator)
    else $error("no wake after start edge");
  a_asleep_quiet: assert property (cpu_asleep_indicator && $past(cpu_asleep_indicator)
    |-> !pipe_valid)
    else $error("data while asleep");
  a_pipe_pulse: assert property (pipe_valid |=> !pipe_valid)
    else $error("pipe strobe too long");
  c_wake: cover property ($fell(cpu_asleep_indicator));
  c_pipe: cover property (pipe_valid);
  c_hib: cover property (hibernating);
endmodule // uwr_wake_rx_properties
`default_nettype wire

// ### verif/uwr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------------------
// host side: serial line and sleep inhibit
// -----------------------------------------------------------------------------
module uwr_host_model #(
  parameter int LEAD = 625
) (
  input wire logic aclk,
  output logic uart_rxd,
  output logic sleep_inhibit_n
);
  initial begin
    uart_rxd = 1'b1; // idle high
    sleep_inhibit_n = 1'b1;
  end
  // one 8/N/1 frame, bc clocks per bit
  task automatic send(input logic [7:0] b, input int bc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      uart_rxd <= f[i];
      repeat (bc) @(posedge aclk);
    end
  endtask
  // dummy null bytes by baud range, then the payload
  task automatic wake_send(input logic [7:0] b, input int bc);
    int n;
    n = (bc >= 61) ? 1 : (bc >= 31) ? 2 : 3;
    repeat (n) send(8'h00, bc);
    send(b, bc);
  endtask
  // inhibit low well ahead of the start bit, held to the end of the stop bit
  task automatic inh_send(input logic [7:0] b, input int bc);
    sleep_inhibit_n <= 1'b0;
    repeat (LEAD) @(posedge aclk);
    send(b, bc);
    sleep_inhibit_n <= 1'b1;
  endtask
endmodule // uwr_host_model
`default_nettype wire

// ### verif/uwr_wake_rx_tb.sv
`timescale 1ns/1ns
`default_nettype none
module uwr_wake_rx_tb;
  localparam int BC = 28; // clocks per bit, about 893 kbaud
  logic aclk = 0, aresetn = 0, forced_shutdown_n = 1, pipe_open = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, r;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cpu_asleep_indicator, hibernating, pipe_valid, uart_rxd, sleep_inhibit_n;
  logic [7:0] pipe_data, x;
  int bad_count = 0, checks = 0, e, c;
  int cq[$], pq[$];
  uwr_wake_rx #(.WAKE_CYC(20)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .uart_rxd(uart_rxd),
    .sleep_inhibit_n(sleep_inhibit_n), .forced_shutdown_n(forced_shutdown_n),
    .pipe_open(pipe_open), .cpu_asleep_indicator(cpu_asleep_indicator),
    .hibernating(hibernating), .pipe_data(pipe_data), .pipe_valid(pipe_valid));
  uwr_host_model #(.LEAD(625)) host (.aclk(aclk), .uart_rxd(uart_rxd),
    .sleep_inhibit_n(sleep_inhibit_n));
  always #20 aclk = ~aclk;
  // collect forwarded pipe bytes
  always @(posedge aclk) if (pipe_valid) pq.push_back(pipe_data);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    chk("bresp", s_axi_bresp, 0);
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 0;
  endtask
  task automatic finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    finish_test;
  end
  // -----------------------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------------------
  initial begin
    c = $urandom(32'h4C0F75D3);
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    axr(4'h8, r);
    chk("stat", r, 32'h09);
    axw(4'h4, BC);
    $display("reset test done");
    // effective level is the lowest of the applicable limits
    repeat (8) begin
      c = $urandom;
      pipe_open <= c[8];
      axw(4'h0, {c[4], 2'(c[3:2] % 3), 2'(c[1:0] % 3)});
      e = c[1:0] % 3;
      if (c[8] && (c[3:2] % 3) < e) e = c[3:2] % 3;
      if (c[4] && e > 1) e = 1;
      axr(4'h8, r);
      chk("level", r[5:0], 6'(e * 8 + 1));
    end
    $display("level test done");
    // deep sleep, wake by dummy bytes, then a command byte
    pipe_open <= 0;
    axw(4'h0, 32'h4A);
    repeat (3) @(posedge aclk);
    chk("asleep", cpu_asleep_indicator, 1);
    x = 8'($urandom_range(255, 1));
    cq.push_back(x);
    fork
      host.wake_send(x, BC);
      begin
        wait (!uart_rxd);
        axw(4'h0, 32'h0A);
      end
    join
    repeat (2 * BC) @(posedge aclk);
    axr(4'hC, r);
    chk("data", r, 32'h100 | cq.pop_front());
    axr(4'hC, r);
    chk("data clr", r, {24'h0, x});
    $display("dummy test done");
    // deep sleep, wake by inhibit pin
    axw(4'h0, 32'h4A);
    x = 8'($urandom_range(255, 1));
    cq.push_back(x);
    fork
      host.inh_send(x, BC);
      begin
        wait (!sleep_inhibit_n);
        repeat (30) @(posedge aclk);
        axw(4'h0, 32'h0A);
      end
    join
    repeat (2 * BC) @(posedge aclk);
    axr(4'hC, r);
    chk("data inh", r, 32'h100 | cq.pop_front());
    $display("inhibit test done");
    // pipe mode forwards null bytes while awake
    pipe_open <= 1;
    axw(4'h0, 32'h2A);
    chk("awake", cpu_asleep_indicator, 0);
    x = 8'($urandom);
    host.send(8'h00, BC);
    host.send(x, BC);
    repeat (2 * BC) @(posedge aclk);
    chk("pipe n", pq.size(), 2);
    if (pq.size() == 2) chk("pipe b", {pq[0][7:0], pq[1][7:0]}, {8'h00, x});
    $display("pipe test done");
    // forced shutdown and release
    forced_shutdown_n <= 0;
    repeat (3) @(posedge aclk);
    chk("hib", {hibernating, cpu_asleep_indicator}, 2'b11);
    forced_shutdown_n <= 1;
    repeat (3) @(posedge aclk);
    chk("hib off", hibernating, 0);
    $display("shutdown test done");
    finish_test;
  end
endmodule // uwr_wake_rx_tb
bind uwr_wake_rx uwr_wake_rx_properties #(.WAKE_CYC(WAKE_CYC)) u_prop (.aclk(aclk),
  .aresetn(aresetn), .uart_rxd(uart_rxd), .sleep_inhibit_n(sleep_inhibit_n),
  .forced_shutdown_n(forced_shutdown_n), .cpu_asleep_indicator(cpu_asleep_indicator),
  .hibernating(hibernating), .pipe_valid(pipe_valid));
`default_nettype wire
